// [reset_source_pkg.sv]
/*
 * Shared constants and types of the reset source controller:
 * register offsets, flag positions, reset values and the carrier
 * for the individual reset detector levels.
 * Assumes a 16-bit register port with a 4-bit word address.
 */
package reset_source_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NUM_SRC = 11;

    // register offsets (word addresses)
    localparam logic [3:0] CAUSE_OFS = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h1;
    localparam logic [3:0] IRQ_CLEAR_OFS = 4'h2;
    localparam logic [3:0] IRQ_ENABLE_OFS = 4'h3;
    localparam logic [3:0] OSC_CTRL_OFS = 4'h4;
    localparam logic [3:0] SRC_LEVEL_OFS = 4'h5;

    // flag positions, shared by cause, status, enable and level
    localparam int POWER_ON_BIT = 0;
    localparam int BROWNOUT_BIT = 1;
    localparam int EXT_CLEAR_BIT = 2;
    localparam int RESET_INSTR_BIT = 3;
    localparam int WATCHDOG_BIT = 4;
    localparam int CFG_MISMATCH_BIT = 5;
    localparam int TRAP_CONFLICT_BIT = 6;
    localparam int ILLEGAL_COND_BIT = 7;
    localparam int ILLEGAL_OPCODE_BIT = 8;
    localparam int UNINIT_WREG_BIT = 9;
    localparam int SECURITY_BIT = 10;

    // new oscillator field inside the oscillator control register
    localparam int NEW_OSCILLATOR_FIELD_LSB = 8;
    localparam int NEW_OSCILLATOR_FIELD_MSB = 10;
    localparam int NEW_OSCILLATOR_FIELD_W = 3;

    // reset values
    localparam logic [10:0] CAUSE_POR_VALUE = 11'h003;
    localparam logic [10:0] IRQ_STATUS_RESET = 11'h000;
    localparam logic [10:0] IRQ_ENABLE_RESET = 11'h000;
    localparam logic [10:0] SRC_PREV_RESET = 11'h000;
    localparam logic [15:0] RD_DATA_RESET = 16'h0000;

    // one level per reset detector; power_on sits in bit 0
    typedef struct packed {
        logic security;
        logic uninit_wreg;
        logic illegal_opcode;
        logic illegal_condition;
        logic trap_conflict;
        logic config_mismatch;
        logic watchdog_timeout;
        logic reset_instruction;
        logic external_clear_pin;
        logic brownout;
        logic power_on;
    } reset_sources_s;

endpackage : reset_source_pkg

// [sticky_flag_cell.sv]
/*
 * One sticky status bit: forced pattern first, hardware set next,
 * software load last, so an event never loses against a clear.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module sticky_flag_cell #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic force_in,
    input wire logic force_value_in,
    input wire logic set_in,
    input wire logic load_in,
    input wire logic load_value_in,
    output logic flag_out
);

    logic flag_reg;

    // force beats set, set beats software load
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            flag_reg <= RESET_VALUE;
        end else if (force_in) begin
            flag_reg <= force_value_in;
        end else if (set_in) begin
            flag_reg <= 1'b1;
        end else if (load_in) begin
            flag_reg <= load_value_in;
        end
    end

    assign flag_out = flag_reg;

endmodule : sticky_flag_cell

// [reset_source_controller.sv]
/*
 * Reset source controller: merges all reset detectors into the
 * master system reset, keeps sticky cause flags, latches new
 * reset events as interrupt status (irq_out rises only once software
 * re-enables them, as each reset clears the enable) and reloads the new oscillator
 * field from configuration on every reset.
 * Assumes detector levels synchronous to clk_sys_in, a register
 * master that never overlaps read and write strobes, and that
 * rst_n_in is the controller's own power-up reset.
 */
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module reset_source_controller (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input reset_source_pkg::reset_sources_s sources_in,
    input wire logic [2:0] default_oscillator_select_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic master_system_reset_out,
    output logic [2:0] new_oscillator_field_out,
    output logic irq_out
);

    // detector levels as a flat vector, bit order of the package
    logic [10:0] src_vec;
    // previous levels, for rising-edge event detection
    logic [10:0] src_prev_reg;
    // one-cycle pulse per source that just became active
    logic [10:0] src_event;
    // sticky cause flags
    logic [10:0] cause_flags;
    // sticky interrupt status and its enable mask
    logic [10:0] irq_status;
    logic [10:0] irq_enable_reg;
    // new oscillator field and its next value
    logic [2:0] new_oscillator_field_reg;
    logic [2:0] new_oscillator_field_next;
    // read data, valid only in the cycle after a read strobe
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    // decoded register writes
    logic wr_cause;
    logic wr_irq_clear;
    logic wr_irq_enable;
    logic wr_osc;
    // master reset level, combined from all detectors
    logic sys_reset;
    logic por_active;

    // flatten the detector struct
    assign src_vec = sources_in;
    assign por_active = sources_in.power_on;

    // any single active source holds the whole device in reset
    assign sys_reset = |src_vec;
    assign master_system_reset_out = sys_reset;

    // write decode; a write never touches the reset path itself
    assign wr_cause = reg_wr_in && (reg_addr_in == reset_source_pkg::CAUSE_OFS);
    assign wr_irq_clear = reg_wr_in &&
        (reg_addr_in == reset_source_pkg::IRQ_CLEAR_OFS);
    assign wr_irq_enable = reg_wr_in &&
        (reg_addr_in == reset_source_pkg::IRQ_ENABLE_OFS);
    assign wr_osc = reg_wr_in &&
        (reg_addr_in == reset_source_pkg::OSC_CTRL_OFS);

    // remember last detector levels for edge detection
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            src_prev_reg <= reset_source_pkg::SRC_PREV_RESET;
        end else begin
            src_prev_reg <= src_vec;
        end
    end

    // a source that was idle and is now active is one new event
    assign src_event = src_vec & ~src_prev_reg;

    // cause flags and interrupt status, one sticky cell per source
    genvar gi;
    generate
        for (gi = 0; gi < reset_source_pkg::NUM_SRC; gi++) begin : g_flag
            // cause flag: power-on forces the pattern, a source sets
            // its own bit, software writes store the plain value
            sticky_flag_cell #(
                .RESET_VALUE(reset_source_pkg::CAUSE_POR_VALUE[gi])
            ) u_cause (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .force_in(por_active),
                .force_value_in(reset_source_pkg::CAUSE_POR_VALUE[gi]),
                .set_in(src_vec[gi]),
                .load_in(wr_cause),
                .load_value_in(reg_wdata_in[gi]),
                .flag_out(cause_flags[gi])
            );

            // interrupt status: set by a new event, cleared by writing
            // a one to the clear register; set beats clear
            sticky_flag_cell #(
                .RESET_VALUE(reset_source_pkg::IRQ_STATUS_RESET[gi])
            ) u_irq (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .force_in(1'b0),
                .force_value_in(1'b0),
                .set_in(src_event[gi]),
                .load_in(wr_irq_clear && reg_wdata_in[gi]),
                .load_value_in(1'b0),
                .flag_out(irq_status[gi])
            );
        end
    endgenerate

    // interrupt enable: forced to its default by a system reset,
    // unlike the cause flags, which survive it unless power-on forces their pattern
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_enable_reg <= reset_source_pkg::IRQ_ENABLE_RESET;
        end else if (sys_reset) begin
            irq_enable_reg <= reset_source_pkg::IRQ_ENABLE_RESET;
        end else if (wr_irq_enable) begin
            irq_enable_reg <= reg_wdata_in[10:0];
        end
    end

    // level interrupt while any enabled status bit is set
    assign irq_out = |(irq_status & irq_enable_reg);

    // new oscillator field: reloaded from configuration on any reset,
    // otherwise software may pick a new source
    always_comb begin
        new_oscillator_field_next = new_oscillator_field_reg;
        if (sys_reset) begin
            new_oscillator_field_next = default_oscillator_select_in;
        end else if (wr_osc) begin
            new_oscillator_field_next = reg_wdata_in[reset_source_pkg::NEW_OSCILLATOR_FIELD_MSB:
                                     reset_source_pkg::NEW_OSCILLATOR_FIELD_LSB];
        end
    end

    // power-up of the controller also takes the configured default
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            new_oscillator_field_reg <= default_oscillator_select_in;
        end else begin
            new_oscillator_field_reg <= new_oscillator_field_next;
        end
    end

    assign new_oscillator_field_out = new_oscillator_field_reg;

    // read multiplexer; unmapped and write-only offsets read zero
    always_comb begin
        rd_data_next = reset_source_pkg::RD_DATA_RESET;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                reset_source_pkg::CAUSE_OFS: begin
                    rd_data_next[10:0] = cause_flags;
                end
                reset_source_pkg::IRQ_STATUS_OFS: begin
                    rd_data_next[10:0] = irq_status;
                end
                reset_source_pkg::IRQ_ENABLE_OFS: begin
                    rd_data_next[10:0] = irq_enable_reg;
                end
                reset_source_pkg::OSC_CTRL_OFS: begin
                    rd_data_next[reset_source_pkg::NEW_OSCILLATOR_FIELD_MSB:
                                 reset_source_pkg::NEW_OSCILLATOR_FIELD_LSB] = new_oscillator_field_reg;
                end
                reset_source_pkg::SRC_LEVEL_OFS: begin
                    rd_data_next[10:0] = src_vec;
                end
                default: begin
                    rd_data_next = reset_source_pkg::RD_DATA_RESET;
                end
            endcase
        end
    end

    // read data register: stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= reset_source_pkg::RD_DATA_RESET;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign reg_rdata_out = rd_data_reg;

endmodule : reset_source_controller

// [reset_source_checker.sv]
/* port checker of the reset source controller
   assumes it is bound to every controller instance */
`timescale 1ns/100ps
module reset_source_checker (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input reset_source_pkg::reset_sources_s sources_in,
    input wire logic [2:0] default_oscillator_select_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic master_system_reset_out,
    input wire logic [2:0] new_oscillator_field_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic rd_cause;
    logic wr_cause;
    logic rd_osc;
    // decoded register accesses
    assign rd_cause = reg_rd_in && reg_addr_in == reset_source_pkg::CAUSE_OFS;
    assign wr_cause = reg_wr_in && reg_addr_in == reset_source_pkg::CAUSE_OFS;
    assign rd_osc = reg_rd_in && reg_addr_in == reset_source_pkg::OSC_CTRL_OFS;
    sys_reset_a: assert property (
        master_system_reset_out == (sources_in != 11'h000))
        else $error("system reset not the or of sources");
    cause_kept_a: assert property (
        rd_cause && $past(rst_n_in) && !$past(sources_in.power_on)
        |=> (reg_rdata_out[10:0] & $past(sources_in, 2)) == $past(sources_in, 2))
        else $error("reset cause flag missing");
    por_value_a: assert property (
        rd_cause && $past(sources_in.power_on) |=> reg_rdata_out == 16'h0003)
        else $error("power-on cause value wrong");
    sw_store_a: assert property (
        (wr_cause && sources_in == 11'h000) ##1 rd_cause
        |=> reg_rdata_out == {5'h00, $past(reg_wdata_in[10:0], 2)}
            && !$past(master_system_reset_out, 2))
        else $error("software cause write not stored");
    new_oscillator_field_load_a: assert property (
        master_system_reset_out
        |=> new_oscillator_field_out == $past(default_oscillator_select_in))
        else $error("oscillator field not reloaded");
    osc_read_a: assert property (
        rd_osc |=> reg_rdata_out[10:8] == $past(new_oscillator_field_out))
        else $error("oscillator field read wrong");
    irq_quiet_a: assert property (
        master_system_reset_out |=> !irq_out)
        else $error("enable survived system reset");
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read cycle");
    rdata_upper_a: assert property (reg_rd_in |=> reg_rdata_out[15:11] == 5'h00)
        else $error("upper read bits not zero");
    cover property (rd_cause ##1 reg_rdata_out[4]);
    cover property ($rose(irq_out));
    cover property ($rose(master_system_reset_out));
endmodule : reset_source_checker
bind reset_source_controller reset_source_checker chk (.clk_sys_in,
    .rst_n_in, .sources_in, .default_oscillator_select_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .master_system_reset_out, .new_oscillator_field_out, .irq_out);

// [reset_detector_model.sv]
/* reset detector model: raises chosen detector levels
   for a chosen count of cycles; assumes the bench clock */
`timescale 1ns/100ps
module reset_detector_model (
    input wire logic clk_sys_in,
    input wire logic go_in,
    input wire logic [10:0] pattern_in,
    input wire logic [3:0] hold_in,
    output reset_source_pkg::reset_sources_s sources_out
);
    logic [3:0] left_reg;
    // levels stand for hold_in cycles, then drop to idle low
    always_ff @(posedge clk_sys_in) begin
        if (go_in) begin
            sources_out <= reset_source_pkg::reset_sources_s'(pattern_in);
            left_reg <= hold_in;
        end else if (left_reg > 4'h1) begin
            left_reg <= left_reg - 4'h1;
        end else begin
            sources_out <= '0;
            left_reg <= 4'h0;
        end
    end
endmodule : reset_detector_model

// [reset_source_controller_tb_top.sv]
/* self-checking bench of the reset source controller
   assumes the detector model and the bound checker */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module reset_source_controller_tb_top;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic go = 1'b0;
    logic [10:0] pat = 11'h000;
    logic [3:0] hold = 4'h1;
    logic [2:0] dflt = 3'h5;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic msr;
    logic [2:0] new_oscillator_field;
    logic irq;
    reset_source_pkg::reset_sources_s src;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] lfsr = 32'h0842;
    reset_detector_model model (.clk_sys_in, .go_in(go), .pattern_in(pat),
        .hold_in(hold), .sources_out(src));
    reset_source_controller dut (.clk_sys_in, .rst_n_in, .sources_in(src),
        .default_oscillator_select_in(dflt), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .master_system_reset_out(msr),
        .new_oscillator_field_out(new_oscillator_field), .irq_out(irq));
    // clock and hang guard
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rand
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // write then read back at once, strobes with no gap between them
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] w,
        output logic [15:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= w;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : wr_rd
    // detector pulse: reset seen at once, cause read while a hold over one cycle stands,
    // live levels read as well when the hold is long enough
    task automatic pulse(input logic [10:0] p, input logic [3:0] h,
        input logic [15:0] c);
        logic [15:0] d;
        @(posedge clk_sys_in);
        pat <= p;
        hold <= h;
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        #1 `CHK("reset", 1'b1, msr)
        rd_reg(reset_source_pkg::CAUSE_OFS, d);
        `CHK("cause live", c, d)
        if (h > 4'h3) begin
            rd_reg(reset_source_pkg::SRC_LEVEL_OFS, d);
            `CHK("level", ({5'h00, p}), d)
            repeat (h - 4'h4) @(posedge clk_sys_in);
        end else if (h > 4'h2) begin
            @(posedge clk_sys_in);
        end
        #1 `CHK("reset off", 1'b0, msr)
    endtask : pulse
    initial begin
        logic [15:0] d;
        int i;
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_reg(reset_source_pkg::CAUSE_OFS, d);
        `CHK("cause", 16'h0003, d)
        wr_reg(reset_source_pkg::CAUSE_OFS, 16'h0000);
        for (i = 1; i < 11; i++) begin
            lfsr = next_rand(lfsr);
            dflt <= lfsr[2:0];
            pulse(11'h001 << i, {2'b00, lfsr[5:4]} + 4'h1,
                16'h0001 << i);
            `CHK("new_oscillator_field", dflt, new_oscillator_field)
            rd_reg(reset_source_pkg::OSC_CTRL_OFS, d);
            `CHK("osc", dflt, d[10:8])
            rd_reg(reset_source_pkg::CAUSE_OFS, d);
            `CHK("cause", 16'h0001 << i, d)
            rd_reg(reset_source_pkg::IRQ_STATUS_OFS, d);
            `CHK("status", 16'h0001 << i, d)
            wr_reg(reset_source_pkg::CAUSE_OFS, 16'h0000);
            wr_reg(reset_source_pkg::IRQ_CLEAR_OFS, 16'h0001 << i);
        end
        // interrupt enable lost on reset, then raise, mask, clear
        wr_reg(reset_source_pkg::IRQ_ENABLE_OFS, 16'h0010);
        pulse(11'h010, 4'h1, 16'h0010);
        rd_reg(reset_source_pkg::IRQ_ENABLE_OFS, d);
        `CHK("enable", 16'h0000, d)
        wr_reg(reset_source_pkg::IRQ_ENABLE_OFS, 16'h0010);
        `CHK("irq", 1'b1, irq)
        wr_reg(reset_source_pkg::IRQ_ENABLE_OFS, 16'h0000);
        `CHK("irq masked", 1'b0, irq)
        wr_reg(reset_source_pkg::IRQ_ENABLE_OFS, 16'h0010);
        wr_reg(reset_source_pkg::IRQ_CLEAR_OFS, 16'h0010);
        `CHK("irq cleared", 1'b0, irq)
        // software writes are stored and start no reset
        repeat (8) begin
            lfsr = next_rand(lfsr);
            wr_rd(reset_source_pkg::CAUSE_OFS, lfsr[15:0], d);
            `CHK("no reset", 1'b0, msr)
            `CHK("cause", ({5'h00, lfsr[10:0]}), d)
        end
        pulse(11'h001, 4'h4, 16'h0003);
        rd_reg(reset_source_pkg::CAUSE_OFS, d);
        `CHK("power on", 16'h0003, d)
        rd_reg(4'hf, d);
        `CHK("unmapped", 16'h0000, d)
        // mid-run controller reset brings the power-up values back
        wr_reg(reset_source_pkg::CAUSE_OFS, 16'h07fc);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_reg(reset_source_pkg::CAUSE_OFS, d);
        `CHK("cause after reset", 16'h0003, d)
        rd_reg(reset_source_pkg::IRQ_STATUS_OFS, d);
        `CHK("status after reset", 16'h0000, d)
        complete_run();
    end
endmodule : reset_source_controller_tb_top
